// ### inc/encoder_map.vh
`ifndef ENCODER_MAP_VH
`define ENCODER_MAP_VH

// register byte offsets
`define ADDR_CTRL       5'h00
`define ADDR_TOTAL      5'h04
`define ADDR_STEPS      5'h08
`define ADDR_NUM        5'h0c
`define ADDR_DEN        5'h10
`define ADDR_CTOTAL     5'h14
`define ADDR_POS        5'h18
`define ADDR_OFFSET     5'h1c

// control register fields
`define CTRL_MODE_LSB   0
`define CTRL_MODE_MSB   1
`define CTRL_W16        2
`define CTRL_DIR        3
`define CTRL_READY      4
`define CTRL_NORMAL     5
`define CTRL_BUSY       6

// operating modes
`define MODE_BASIC      2'h0
`define MODE_FULL       2'h1
`define MODE_GEAR       2'h2
`define MODE_TEACH      2'h3

// reset values
`define RST_TOTAL       26'h1000000
`define RST_STEPS       14'h1000
`define RST_NUM         16'h1000
`define RST_DEN         7'h01

// parameter limits
`define MAX_STEPS       14'h2000
`define MAX_NUM         16'hf400
`define MAX_DEN         7'h64

// sensor layout
`define FINE_BITS       13
`define TURN_BITS       12
`define MAX_LOG2        4'hc

// cyclic word bit positions
`define TRIG32_BIT      31
`define TRIG16_BIT      15
`define ST_READY_BIT    25
`define ST_NORMAL_BIT   26
`define DIRCHG_BIT      28

// timing
`define CLK_KHZ         125000
`define RESP_TIME_MS    30
`define FILT_TIME_MS    30

`endif

// ### rtl/encoder_scaling_preset_teachin.v
// Functional notes
// RULE1 - basic modes: binary, offset, direction, no gear
// RULE2 - basic modes: revolutions cut to power of two
// RULE3 - corrected total length readable, below configured
// RULE4 - raw position repeats every 4096 revolutions
// RULE5 - gear modes: steps per turn from gear
// RULE6 - gear parameters held within their limits
// RULE7 - preset accepted from zero to total minus one
// RULE8 - master raises top output bit for preset
// RULE9 - preset taken on rising trigger edge
// RULE10 - trigger must hold for full response time
// RULE11 - re-arm after release plus filter time
// RULE12 - full profile mode gives no preset acknowledge
// RULE13 - teach-in handles only direction and adjust
// RULE14 - teach-in status replaces position bits 25..31
// RULE15 - status bit 25 shows ready
// RULE16 - status bit 26 shows normal mode
// RULE17 - status bit 28 shows counting direction
// RULE18 - status bit 31 acknowledges executed adjustment; also set for an out-of-range preset that is not applied
// RULE19 - control bit 28 inverts counting direction
// RULE20 - control bit 31 requests adjustment to preset
// RULE21 - direction handshake echoes in bits 0, 28
// RULE22 - preset handshake ends when bit 31 clears
// RULE23 - meaningless status bits zero, control ignored
`timescale 1ns/1ps
`include "encoder_map.vh"
`default_nettype none

module encoder_scaling_preset_teachin #(
  parameter integer RESP_CYCLES = `RESP_TIME_MS * `CLK_KHZ,
  parameter integer FILT_CYCLES = `FILT_TIME_MS * `CLK_KHZ,
  parameter integer CNT_W       = 22
) (
  // clock and reset
  input  wire        ref_clk,
  input  wire        nrst,
  // register port
  input  wire [4:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  // raw absolute sensor position
  input  wire [12:0] raw_fine,
  input  wire [11:0] raw_turn,
  // cyclic process data
  input  wire [31:0] out_data,
  output reg  [31:0] in_data
);

  localparam [2:0] S_CFG1 = 3'b001;
  localparam [2:0] S_CFG2 = 3'b010;
  localparam [2:0] S_POS  = 3'b100;
  localparam [3:0] T_IDLE = 4'b0001;
  localparam [3:0] T_QUAL = 4'b0010;
  localparam [3:0] T_HOLD = 4'b0100;
  localparam [3:0] T_FILT = 4'b1000;
  localparam integer     RESP_M1   = RESP_CYCLES - 1;
  localparam integer     FILT_M1   = FILT_CYCLES - 1;
  localparam [CNT_W-1:0] RESP_LAST = RESP_M1[CNT_W-1:0];
  localparam [CNT_W-1:0] FILT_LAST = FILT_M1[CNT_W-1:0];

  function [31:0] clamp;
    input [31:0] v;
    input [31:0] hi;
    begin
      if (v == 32'h0)
        clamp = 32'h1;
      else if (v > hi)
        clamp = hi;
      else
        clamp = v;
    end
  endfunction

  function [3:0] floor_log2;
    input [25:0] v;
    integer i;
    begin
      floor_log2 = 4'h0;
      for (i = 1; i <= `MAX_LOG2; i = i + 1) begin
        if (v >= (26'h1 << i))
          floor_log2 = i[3:0];
      end
    end
  endfunction

  // configuration
  reg [1:0]   mode_reg;
  reg         w16_reg;
  reg         dir_reg;
  reg         dir_next;
  reg         rdy_reg;
  reg         normal_reg;
  reg [25:0]  total_reg;
  reg [13:0]  steps_reg;
  reg [15:0]  num_reg;
  reg [6:0]   den_reg;
  reg         cfg_dirty_reg;
  reg         busy_reg;
  wire        cfg_wr;
  wire [31:0] steps_lim;
  wire [31:0] num_lim;
  wire [31:0] den_lim;
  // derived scaling
  reg [13:0]  ipr_reg;
  reg [25:0]  ctot_reg;
  reg [3:0]   crlog_reg;
  // position state
  reg [15:0]  gturn_reg;
  reg [11:0]  track_reg;
  reg [25:0]  pd_reg;
  reg [25:0]  off_reg;
  reg [25:0]  pos_reg;
  // divider
  reg [47:0]  div_quo_reg;
  reg [26:0]  div_rem_reg;
  reg [25:0]  div_dvs_reg;
  reg [5:0]   div_cnt_reg;
  reg         div_run_reg;
  reg         div_done_reg;
  reg [2:0]   calc_state_reg;
  // preset trigger
  reg [3:0]   trig_state_reg;
  reg [CNT_W-1:0] trig_cnt_reg;
  reg         trig_prev_reg;
  reg         dchg_prev_reg;
  reg         ack_reg;

  wire        gear_mode;
  wire        teach_mode;
  wire        preset_en;
  wire        trig;
  wire [25:0] mod_total;
  wire [11:0] turn_mask;
  wire [11:0] turn_diff;
  wire [38:0] prod_basic;
  wire [42:0] prod_gear;
  wire [47:0] pos_dividend;
  wire [26:0] div_trial;
  wire [25:0] p_now;
  wire [25:0] pd_now;
  wire [26:0] pos_sum;
  wire [25:0] preset_val;
  wire        preset_go;
  wire [32:0] total_den;

  assign gear_mode  = (mode_reg == `MODE_GEAR) || teach_mode;  // [RULE5]
  assign teach_mode = (mode_reg == `MODE_TEACH);
  // preset only in full profile, gear and teach-in modes
  assign preset_en  = (mode_reg != `MODE_BASIC);  // [RULE7]
  // trigger is the top bit of the word in use; teach-in always bit 31
  assign trig       = (w16_reg && !teach_mode) ? out_data[`TRIG16_BIT]
                              : out_data[`TRIG32_BIT];  // [RULE8] [RULE9]
  assign mod_total  = gear_mode ? total_reg : ctot_reg;  // [RULE2]
  assign cfg_wr     = reg_wr && ((reg_addr == `ADDR_TOTAL) ||
                      (reg_addr == `ADDR_STEPS) || (reg_addr == `ADDR_NUM) ||
                      (reg_addr == `ADDR_DEN) || (reg_addr == `ADDR_CTRL));

  // basic turns wrap at the corrected power of two, at most 4096
  assign turn_mask  = (12'h1 << crlog_reg) - 12'h1;  // [RULE4]
  assign turn_diff  = raw_turn - track_reg;
  // no gear in basic modes: fixed steps per turn
  assign prod_basic = {raw_turn & turn_mask, raw_fine}
                      * steps_reg;  // [RULE1]
  assign prod_gear  = {gturn_reg, raw_fine} * ipr_reg;  // [RULE5]
  assign pos_dividend = gear_mode ? {18'h0, prod_gear[42:`FINE_BITS]}
                                  : {22'h0, prod_basic[38:`FINE_BITS]};
  assign total_den  = total_reg * den_reg;
  assign steps_lim  = clamp(reg_wdata, {18'h0, `MAX_STEPS});  // [RULE6]
  assign num_lim    = clamp(reg_wdata, {16'h0, `MAX_NUM});  // [RULE6]
  assign den_lim    = clamp(reg_wdata, {25'h0, `MAX_DEN});  // [RULE6]

  assign div_trial  = {div_rem_reg[25:0], div_quo_reg[47]};
  assign p_now      = div_rem_reg[25:0];
  // counting direction mirrors the scaled position
  assign pd_now     = (dir_reg && (p_now != 26'h0)) ? (mod_total - p_now)
                                                    : p_now;  // [RULE1]
  assign pos_sum    = {1'b0, pd_reg} + {1'b0, off_reg};

  assign preset_val = teach_mode ? {1'b0, out_data[24:0]}
                    : (w16_reg ? {11'h0, out_data[14:0]}
                               : out_data[25:0]);  // [RULE20]
  assign preset_go  = (trig_state_reg == T_QUAL) && trig &&
                      (trig_cnt_reg == RESP_LAST);  // [RULE10]

  // configuration registers
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mode_reg   <= `MODE_BASIC;
      w16_reg    <= 1'b0;
      rdy_reg    <= 1'b0;
      normal_reg <= 1'b0;
      total_reg  <= `RST_TOTAL;
      steps_reg  <= `RST_STEPS;
      num_reg    <= `RST_NUM;
      den_reg    <= `RST_DEN;
    end else if (reg_wr) begin
      case (reg_addr)
        `ADDR_CTRL: begin
          mode_reg   <= reg_wdata[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
          w16_reg    <= reg_wdata[`CTRL_W16];
          rdy_reg    <= reg_wdata[`CTRL_READY];
          normal_reg <= reg_wdata[`CTRL_NORMAL];
        end
        `ADDR_TOTAL: begin
          total_reg <= (reg_wdata[25:0] == 26'h0) ? 26'h1
                                                  : reg_wdata[25:0];
        end
        `ADDR_STEPS: begin
          steps_reg <= steps_lim[13:0];  // [RULE6]
        end
        `ADDR_NUM: begin
          num_reg <= num_lim[15:0];  // [RULE6]
        end
        `ADDR_DEN: begin
          den_reg <= den_lim[6:0];  // [RULE6]
        end
        default: begin
        end
      endcase
    end
  end

  // counting direction: software sets it, teach-in inverts it
  always @* begin
    dir_next = dir_reg;
    if (reg_wr && (reg_addr == `ADDR_CTRL))
      dir_next = reg_wdata[`CTRL_DIR];
    else if (teach_mode && out_data[`DIRCHG_BIT] && !dchg_prev_reg)
      dir_next = ~dir_reg;  // [RULE19] [RULE21]
  end

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dir_reg       <= 1'b0;
      dchg_prev_reg <= 1'b0;
    end else begin
      dir_reg       <= dir_next;
      dchg_prev_reg <= out_data[`DIRCHG_BIT];
    end
  end

  // shaft turns tracked modulo the gear numerator
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      gturn_reg <= 16'h0;
      track_reg <= 12'h0;
    end else if (cfg_wr) begin
      gturn_reg <= 16'h0;
      track_reg <= raw_turn;
    end else if (turn_diff != 12'h0) begin
      if (!turn_diff[11]) begin
        track_reg <= track_reg + 12'h1;
        gturn_reg <= (gturn_reg >= num_reg - 16'h1) ? 16'h0
                                                    : gturn_reg + 16'h1;
      end else begin
        track_reg <= track_reg - 12'h1;
        gturn_reg <= (gturn_reg == 16'h0) ? num_reg - 16'h1
                                          : gturn_reg - 16'h1;
      end
    end
  end

  // shared sequential divider and calculation sequence
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      div_quo_reg    <= 48'h0;
      div_rem_reg    <= 27'h0;
      div_dvs_reg    <= 26'h1;
      div_cnt_reg    <= 6'h0;
      div_run_reg    <= 1'b0;
      div_done_reg   <= 1'b0;
      calc_state_reg <= S_CFG1;
      cfg_dirty_reg  <= 1'b1;
      busy_reg       <= 1'b1;
      ipr_reg        <= `RST_STEPS;
      ctot_reg       <= `RST_TOTAL;
      crlog_reg      <= `MAX_LOG2;
      pd_reg         <= 26'h0;
    end else begin
      div_done_reg <= 1'b0;
      busy_reg     <= busy_reg || cfg_wr;
      if (cfg_wr)
        cfg_dirty_reg <= 1'b1;
      if (div_run_reg) begin
        if (div_trial >= {1'b0, div_dvs_reg}) begin
          div_rem_reg <= div_trial - {1'b0, div_dvs_reg};
          div_quo_reg <= {div_quo_reg[46:0], 1'b1};
        end else begin
          div_rem_reg <= div_trial;
          div_quo_reg <= {div_quo_reg[46:0], 1'b0};
        end
        div_cnt_reg <= div_cnt_reg - 6'h1;
        if (div_cnt_reg == 6'h1) begin
          div_run_reg  <= 1'b0;
          div_done_reg <= 1'b1;
        end
      end else if (div_done_reg) begin
        case (calc_state_reg)
          S_CFG1: begin
            // gear steps per turn = total * den / num
            if (div_quo_reg[25:0] == 26'h0)
              ipr_reg <= 14'h1;
            else if (div_quo_reg[25:0] > {12'h0, `MAX_STEPS})
              ipr_reg <= `MAX_STEPS;  // [RULE6]
            else
              ipr_reg <= div_quo_reg[13:0];  // [RULE5]
            calc_state_reg <= S_CFG2;
          end
          S_CFG2: begin
            // corrected length: steps times power-of-two turns
            crlog_reg <= floor_log2(div_quo_reg[25:0]);  // [RULE2]
            ctot_reg  <= {12'h0, steps_reg}
                         << floor_log2(div_quo_reg[25:0]);  // [RULE3]
            calc_state_reg <= S_POS;
          end
          S_POS: begin
            pd_reg <= pd_now;
            // busy until a position from the current setup is in
            busy_reg <= cfg_dirty_reg || cfg_wr;
            if (cfg_dirty_reg)
              calc_state_reg <= S_CFG1;
          end
          default: begin
            calc_state_reg <= S_CFG1;
          end
        endcase
      end else begin
        div_run_reg <= 1'b1;
        div_cnt_reg <= 6'h30;
        div_rem_reg <= 27'h0;
        case (calc_state_reg)
          S_CFG1: begin
            cfg_dirty_reg <= cfg_wr;
            div_quo_reg   <= {15'h0, total_den};
            div_dvs_reg   <= {10'h0, num_reg};
          end
          S_CFG2: begin
            div_quo_reg <= {22'h0, total_reg};
            div_dvs_reg <= {12'h0, steps_reg};
          end
          default: begin
            div_quo_reg <= pos_dividend;
            div_dvs_reg <= mod_total;
          end
        endcase
      end
    end
  end

  // preset trigger: qualify, hold, then filter after release
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      trig_state_reg <= T_IDLE;
      trig_cnt_reg   <= {CNT_W{1'b0}};
      trig_prev_reg  <= 1'b0;
    end else begin
      trig_prev_reg <= trig;
      case (trig_state_reg)
        T_IDLE: begin
          trig_cnt_reg <= {CNT_W{1'b0}};
          if (preset_en && trig && !trig_prev_reg)
            trig_state_reg <= T_QUAL;  // [RULE9]
        end
        T_QUAL: begin
          if (!trig) begin
            trig_state_reg <= T_IDLE;  // [RULE10]
          end else if (trig_cnt_reg == RESP_LAST) begin
            trig_state_reg <= T_HOLD;
          end else begin
            trig_cnt_reg <= trig_cnt_reg + 1'b1;
          end
        end
        T_HOLD: begin
          trig_cnt_reg <= {CNT_W{1'b0}};
          if (!trig)
            trig_state_reg <= T_FILT;  // [RULE11]
        end
        T_FILT: begin
          if (trig) begin
            trig_state_reg <= T_HOLD;  // [RULE11]
          end else if (trig_cnt_reg == FILT_LAST) begin
            trig_state_reg <= T_IDLE;
          end else begin
            trig_cnt_reg <= trig_cnt_reg + 1'b1;
          end
        end
        default: begin
          trig_state_reg <= T_IDLE;
          trig_cnt_reg   <= {CNT_W{1'b0}};
        end
      endcase
    end
  end

  // zero offset and output position
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      off_reg <= 26'h0;
      pos_reg <= 26'h0;
      ack_reg <= 1'b0;
    end else begin
      if (preset_go && (preset_val < mod_total)) begin
        off_reg <= (preset_val >= pd_reg)
                   ? preset_val - pd_reg
                   : preset_val + mod_total - pd_reg;  // [RULE7] [RULE9]
        pos_reg <= preset_val;
      end else if (pos_sum >= {1'b0, mod_total}) begin
        pos_reg <= pos_sum[25:0] - mod_total;  // [RULE1]
      end else begin
        pos_reg <= pos_sum[25:0];
      end
      // acknowledge only in teach-in; set wins over clear
      if (teach_mode && preset_go)
        ack_reg <= 1'b1;  // [RULE18] [RULE12]
      else if (!trig || !teach_mode)
        ack_reg <= 1'b0;  // [RULE22]
    end
  end

  // cyclic input word
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      in_data <= 32'h0;
    end else if (teach_mode) begin
      // bits 27, 29, 30 stay zero; other control bits unused
      in_data[31]    <= ack_reg;  // [RULE14] [RULE18] [RULE23]
      in_data[30:29] <= 2'h0;  // [RULE23]
      in_data[28]    <= dir_reg;  // [RULE17] [RULE21]
      in_data[27]    <= 1'b0;  // [RULE23]
      in_data[`ST_NORMAL_BIT] <= normal_reg;  // [RULE16]
      in_data[`ST_READY_BIT]  <= rdy_reg && !busy_reg;  // [RULE15]
      if (out_data[`DIRCHG_BIT])
        in_data[24:0] <= {24'h0, dir_reg};  // [RULE21] [RULE13]
      else
        in_data[24:0] <= pos_reg[24:0];  // [RULE21] [RULE22]
    end else if (w16_reg) begin
      in_data <= {16'h0, pos_reg[15:0]};  // [RULE12]
    end else begin
      in_data <= {6'h0, pos_reg};
    end
  end

  // register read port
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      case (reg_addr)
        `ADDR_CTRL: begin
          reg_rdata <= {25'h0, busy_reg, normal_reg, rdy_reg,
                        dir_reg, w16_reg, mode_reg};
        end
        `ADDR_TOTAL:  reg_rdata <= {6'h0, total_reg};
        `ADDR_STEPS:  reg_rdata <= {18'h0, steps_reg};
        `ADDR_NUM:    reg_rdata <= {16'h0, num_reg};
        `ADDR_DEN:    reg_rdata <= {25'h0, den_reg};
        `ADDR_CTOTAL: reg_rdata <= {6'h0, mod_total};  // [RULE3]
        `ADDR_POS:    reg_rdata <= {6'h0, pos_reg};
        `ADDR_OFFSET: reg_rdata <= {6'h0, off_reg};
        default:      reg_rdata <= 32'h0;
      endcase
    end
  end

endmodule

`default_nettype wire

// ### tb/encoder_checker_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "encoder_map.vh"
module encoder_checker #(
  parameter integer RESP_CYCLES = 8
) (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        nrst,
  // register port
  input wire logic [4:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  // sensor and cyclic data
  input wire logic [12:0] raw_fine,
  input wire logic [11:0] raw_turn,
  input wire logic [31:0] out_data,
  input wire logic [31:0] in_data
);
  logic [1:0]  mode_reg;
  logic [2:0]  age_reg;
  logic [25:0] total_reg;
  logic [15:0] run_reg;
  wire         teach_q = mode_reg == `MODE_TEACH && age_reg == 3'h7;
  wire         full_q  = mode_reg == `MODE_FULL && age_reg == 3'h7;

  // shadow of the mode, its age and the configured length
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mode_reg <= 2'h0;
      age_reg <= 3'h0;
      total_reg <= `RST_TOTAL;
      run_reg <= 16'h0;
    end else begin
      if (reg_wr && reg_addr == `ADDR_CTRL) begin
        mode_reg <= reg_wdata[1:0];
        age_reg <= 3'h0;
      end else if (age_reg != 3'h7) begin
        age_reg <= age_reg + 3'h1;
      end
      if (reg_wr && reg_addr == `ADDR_TOTAL) begin
        total_reg <= reg_wdata[25:0];
      end
      if (!out_data[31]) begin
        run_reg <= 16'h0;
      end else if (run_reg != 16'hffff) begin
        run_reg <= run_reg + 16'h1;
      end
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  property p_steps;
    reg_rd && reg_addr == `ADDR_STEPS |=>
      reg_rdata >= 32'h1 && reg_rdata <= 32'h2000;
  endproperty
  a_steps: assert property (p_steps) else $error("steps out of range");
  property p_num;
    reg_rd && reg_addr == `ADDR_NUM |=>
      reg_rdata >= 32'h1 && reg_rdata <= 32'hf400;
  endproperty
  a_num: assert property (p_num) else $error("revs out of range");
  property p_den;
    reg_rd && reg_addr == `ADDR_DEN |=>
      reg_rdata >= 32'h1 && reg_rdata <= 32'h64;
  endproperty
  a_den: assert property (p_den) else $error("denominator out of range");
  property p_ctotal;
    reg_rd && reg_addr == `ADDR_CTOTAL && mode_reg == `MODE_BASIC |=>
      reg_rdata <= {6'h0, total_reg};
  endproperty
  a_ctotal: assert property (p_ctotal) else $error("length grew");
  property p_noack;
    full_q |-> !in_data[31];
  endproperty
  a_noack: assert property (p_noack) else $error("ack in full mode");
  property p_spare;
    teach_q |-> in_data[27] == 1'b0 && in_data[30:29] == 2'h0;
  endproperty
  a_spare: assert property (p_spare) else $error("spare status set");
  property p_hold;
    teach_q && $rose(in_data[31]) |-> run_reg >= RESP_CYCLES;
  endproperty
  a_hold: assert property (p_hold) else $error("preset too early");
  property p_clear;
    teach_q && !out_data[31] ##1 !out_data[31] |=> !in_data[31];
  endproperty
  a_clear: assert property (p_clear) else $error("ack not cleared");
  property p_echo;
    teach_q && $rose(out_data[28]) ##1 out_data[28] [*3] |->
      in_data[28] != $past(in_data[28], 3) && in_data[0] == in_data[28]
      && in_data[24:1] == 24'h0;
  endproperty
  a_echo: assert property (p_echo) else $error("direction echo wrong");

  c_ack: cover property (teach_q && $rose(in_data[31]));
  c_dir: cover property (teach_q && $rose(out_data[28]));
  c_full: cover property (full_q && $rose(out_data[31]));
endmodule

bind encoder_scaling_preset_teachin encoder_checker #(
  .RESP_CYCLES(RESP_CYCLES)
) encoder_checker_inst (
  .ref_clk(ref_clk),
  .nrst(nrst),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .raw_fine(raw_fine),
  .raw_turn(raw_turn),
  .out_data(out_data),
  .in_data(in_data)
);
`default_nettype wire

// ### tb/cyclic_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module cyclic_master_model (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  // bench command
  input  wire logic [31:0] word,
  input  wire logic        auto_release,
  // cyclic data
  input  wire logic [31:0] in_data,
  output var  logic [31:0] out_data
);
  logic released;
  logic rel_next;

  // drop the trigger as soon as the ack is seen, until the bench lets go
  assign rel_next = word[31] && (released || (auto_release && in_data[31]));

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      out_data <= 32'h0;
      released <= 1'b0;
    end else begin
      out_data <= {word[31] && !rel_next, word[30:0]};
      released <= rel_next;
    end
  end
endmodule
`default_nettype wire

// ### tb/encoder_scaling_preset_teachin_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "encoder_map.vh"
module encoder_scaling_preset_teachin_tb;
  logic        ref_clk;
  logic        nrst;
  logic        reg_wr;
  logic        reg_rd;
  logic        auto_release;
  logic [4:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic [31:0] word;
  logic [31:0] out_data;
  logic [31:0] in_data;
  logic [31:0] got;
  logic [12:0] raw_fine;
  logic [11:0] raw_turn;
  int          num_errors;
  int          n_tests;
  int          cycles;
  logic [4:0]  t_adr [9] = '{5'h08, 5'h08, 5'h08, 5'h10, 5'h10, 5'h10,
                             5'h0c, 5'h0c, 5'h0c};
  logic [31:0] t_val [9] = '{32'h3fff, 32'h0, 32'h1000, 32'h0, 32'hc8,
                             32'h1, 32'hffff, 32'h0, 32'h1000};
  logic [31:0] t_exp [9] = '{32'h2000, 32'h1, 32'h1000, 32'h1, 32'h64,
                             32'h1, 32'hf400, 32'h1, 32'h1000};

  always #4 ref_clk = ~ref_clk;

  encoder_scaling_preset_teachin #(
    .RESP_CYCLES(8),
    .FILT_CYCLES(8)
  ) encoder_scaling_preset_teachin_inst (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .raw_fine(raw_fine),
    .raw_turn(raw_turn),
    .out_data(out_data),
    .in_data(in_data)
  );

  cyclic_master_model cyclic_master_model_inst (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .word(word),
    .auto_release(auto_release),
    .in_data(in_data),
    .out_data(out_data)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rchk(input logic [4:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 got = reg_rdata;
    chk(got, exp);
  endtask

  task automatic wait_busy;
    for (int k = 0; k < 300; k++) begin
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= `ADDR_CTRL;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 got = reg_rdata;
      if (got[`CTRL_BUSY] === 1'b0) break;
    end
    if (got[`CTRL_BUSY] !== 1'b0) num_errors++;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // drive a word, let it settle, then look at the input word
  task automatic push(input logic [31:0] w, input int n,
                      input logic [31:0] exp);
    @(posedge ref_clk);
    word <= w;
    cyc(n);
    @(negedge ref_clk);
    chk(in_data, exp);
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      wrap_up();
    end
  end

  initial begin
    ref_clk = 1'b0;
    nrst = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    auto_release = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 32'h0;
    word = 32'h0;
    raw_fine = 13'h0100;
    raw_turn = 12'h005;
    cyc(16);
    nrst <= 1'b1;
    wait_busy();
    rchk(`ADDR_TOTAL, 32'h01000000);
    rchk(5'h01, 32'h0);
    for (int k = 0; k < 9; k++) begin
      wr(t_adr[k], t_val[k]);
      rchk(t_adr[k], t_exp[k]);
    end
    $display("test registers done");
    wait_busy();
    push(32'h0, 120, 32'h00005080);
    wr(`ADDR_CTRL, 32'h08);
    wait_busy();
    cyc(120);
    rchk(`ADDR_POS, 32'h00ffaf80);
    wr(`ADDR_CTRL, 32'h00);
    wr(`ADDR_TOTAL, 32'h00bb8000);
    wait_busy();
    rchk(`ADDR_CTOTAL, 32'h00800000);
    @(posedge ref_clk) raw_turn <= 12'h805;
    push(32'h80001234, 120, 32'h00005080);
    @(posedge ref_clk) raw_turn <= 12'h005;
    wr(`ADDR_TOTAL, 32'h01000000);
    $display("test basic done");
    wr(`ADDR_CTRL, 32'h01);
    wait_busy();
    push(32'h0, 120, 32'h00005080);
    push(32'h80001234, 4, 32'h00005080);
    push(32'h0, 20, 32'h00005080);
    push(32'h80001234, 20, 32'h00001234);
    push(32'h0, 3, 32'h00001234);
    push(32'h80002222, 20, 32'h00001234);
    push(32'h0, 14, 32'h00001234);
    push(32'h80002222, 20, 32'h00002222);
    push(32'h0, 14, 32'h00002222);
    push(32'h81000000, 20, 32'h00002222);
    push(32'h0, 14, 32'h00002222);
    push(32'h80ffffff, 20, 32'h00ffffff);
    push(32'h0, 2, 32'h00ffffff);
    wr(`ADDR_CTRL, 32'h05);
    wait_busy();
    push(32'h00008777, 20, 32'h00000777);
    push(32'h0, 14, 32'h00000777);
    $display("test full profile done");
    wr(`ADDR_CTRL, 32'h02);
    wr(`ADDR_TOTAL, 32'h00200000);
    wr(`ADDR_NUM, 32'h0100);
    wait_busy();
    rchk(`ADDR_CTOTAL, 32'h00200000);
    push(32'h80000010, 20, 32'h00000010);
    @(posedge ref_clk) raw_fine <= 13'h0120;
    push(32'h0, 120, 32'h00000030);
    @(posedge ref_clk) raw_turn <= 12'h006;
    push(32'h0, 120, 32'h00002030);
    $display("test gear done");
    wr(`ADDR_CTRL, 32'h33);
    wait_busy();
    cyc(120);
    @(negedge ref_clk);
    chk({25'h0, in_data[31:25]}, 32'h03);
    push(32'h7e000000, 6, 32'h16000001);
    rchk(`ADDR_CTRL, 32'h3b);
    push(32'h0, 120, 32'h161ffdf0);
    push(32'h10000000, 6, 32'h06000000);
    push(32'h0, 120, 32'h06000030);
    push(32'h80004321, 20, 32'h86004321);
    push(32'h0, 120, 32'h06004321);
    @(posedge ref_clk) auto_release <= 1'b1;
    push(32'h80000555, 20, 32'h06000555);
    push(32'h0, 20, 32'h06000555);
    wr(`ADDR_CTRL, 32'h13);
    wait_busy();
    push(32'h0, 4, 32'h02000555);
    wr(`ADDR_CTRL, 32'h03);
    wait_busy();
    push(32'h0, 4, 32'h00000555);
    $display("test teach-in done");
    wrap_up();
  end
endmodule
`default_nettype wire
